// ===== hdl/cmc_top.sv
/*
 Line front end of a CSMA/CD serial channel: APB registers, sample and
 bit rate divider, Manchester receive checker with collision and idle
 detection, and the interframe space deference timer.
 Assumes the receive pin and tx_pending are synchronous to pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module cmc_top
(
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic [cmc_pkg::CMC_AW-1:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error
   input wire logic serial_receive_pin, // Line receive data
   input wire logic tx_pending, // New message waiting to send
   output logic tx_allowed, // Deference over, transmit may start
   output logic collision, // One cycle collision pulse
   output logic rx_bit, // Line level after the last mid or boundary transition
   output logic rx_bit_valid, // One cycle pulse with rx_bit
   output logic line_idle_flag, // Line idle status
   output logic manchester_sel // Manchester coding in use
);
   import cmc_pkg::*;

   function automatic logic [2:0] reg_index(input logic [CMC_AW-1:0] a);
      case (a)
         CMC_OFF_IFS: reg_index = 3'h4;
         CMC_OFF_CTRL: reg_index = 3'h5;
         CMC_OFF_STATUS: reg_index = 3'h6;
         CMC_OFF_SAMPDIV: reg_index = 3'h7;
         default: reg_index = 3'h0;
      endcase
   endfunction

   logic [6:0] ifs_q, ifs_d;
   cmc_ctrl_t ctrl_q, ctrl_d;
   logic [7:0] sdiv_q, sdiv_d;
   logic coll_st_q, coll_st_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic manch_q, manch_d;

   logic [7:0] divc_q, divc_d;
   logic [2:0] phase_q, phase_d;
   logic samp_en_q, samp_en_d;
   logic bit_en_q, bit_en_d;

   logic rx_prev_q, rx_prev_d;
   logic [4:0] run_q, run_d;
   logic mid_ref_q, mid_ref_d;
   logic eof_pend_q, eof_pend_d;
   logic [2:0] dly_q, dly_d;
   logic idle_q, idle_d;
   logic coll_q, coll_d;
   logic rx_bit_q, rx_bit_d;
   logic rxv_q, rxv_d;
   logic edge_ev_q, edge_ev_d;

   cmc_ifs_state_t st_q, st_d;
   logic [8:0] cnt_q, cnt_d;
   logic half_q, half_d;
   logic txok_q, txok_d;

   logic access;
   logic done;
   logic [2:0] idx;
   logic [8:0] period;
   logic [4:0] run_inc;
   logic [4:0] miss_thr;

   assign access = psel & penable;
   assign done = access & pready_q;
   assign idx = reg_index(paddr);

   // Even spacing only; a zero count means the longest period.
   assign period = (ifs_q == CMC_IFS_RST) ? CMC_IFS_ZERO_PERIOD
      : {1'b0, ifs_q, 1'b0}; // R1 R2

   // Registers and APB slave; one wait state per transfer.
   always_comb
   begin
      ifs_d = ifs_q;
      ctrl_d = ctrl_q;
      sdiv_d = sdiv_q;
      coll_st_d = coll_st_q;
      prdata_d = prdata_q;
      pready_d = access & ~pready_q;
      pslverr_d = 1'b0;
      if (access && !pready_q)
      begin
         pslverr_d = ~idx[2];
         case (idx)
            3'h4: prdata_d = {24'h0, ifs_q, half_q}; // R4
            3'h5: prdata_d = {28'h0, ctrl_q};
            3'h6: prdata_d = {27'h0, half_q, rx_bit_q, coll_st_q,
               txok_q, idle_q};
            3'h7: prdata_d = {24'h0, sdiv_q};
            default: prdata_d = 32'h0;
         endcase
      end
      if (done && pwrite)
      begin
         case (idx)
            3'h4: ifs_d = pwdata[7:1]; // R3
            3'h5: ctrl_d = cmc_ctrl_t'(pwdata[CMC_CTRL_W-1:0]);
            3'h6:
            begin
               if (pwdata[CMC_ST_COLL])
               begin
                  coll_st_d = 1'b0;
               end
            end
            3'h7: sdiv_d = pwdata[7:0];
            default: ;
         endcase
      end
      // A collision in the clearing cycle keeps the flag set.
      if (coll_q)
      begin
         coll_st_d = 1'b1;
      end
      manch_d = ctrl_q.csma & ~ctrl_q.ext_1x; // R10 R11
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ifs_q <= CMC_IFS_RST; // R5
         ctrl_q <= CMC_CTRL_RST;
         sdiv_q <= CMC_SAMPDIV_RST;
         coll_st_q <= 1'b0;
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         manch_q <= 1'b0;
      end
      else
      begin
         ifs_q <= ifs_d;
         ctrl_q <= ctrl_d;
         sdiv_q <= sdiv_d;
         coll_st_q <= coll_st_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         manch_q <= manch_d;
      end
   end

   // Sample enable every sdiv+1 clocks; a bit is eight samples.
   always_comb
   begin
      divc_d = divc_q;
      phase_d = phase_q;
      samp_en_d = 1'b0;
      bit_en_d = 1'b0;
      if (divc_q >= sdiv_q)
      begin
         divc_d = 8'h00;
         samp_en_d = 1'b1; // R13 R5
         phase_d = phase_q + 3'h1;
         bit_en_d = (phase_q == CMC_SAMP_LAST);
      end
      else
      begin
         divc_d = divc_q + 8'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         divc_q <= 8'h00;
         phase_q <= 3'h0;
         samp_en_q <= 1'b0;
         bit_en_q <= 1'b0;
      end
      else
      begin
         divc_q <= divc_d;
         phase_q <= phase_d;
         samp_en_q <= samp_en_d;
         bit_en_q <= bit_en_d;
      end
   end

   assign run_inc = (run_q == 5'h1f) ? run_q : run_q + 5'h01;
   // Allowed run before a missing transition depends on where the last
   // transition fell: edge allows a half bit, mid cell a full bit.
   assign miss_thr = mid_ref_q ? CMC_MISS_MID : CMC_MISS_EDGE; // R14

   // Receive checker working on the sample stream.
   always_comb
   begin
      rx_prev_d = rx_prev_q;
      run_d = run_q;
      mid_ref_d = mid_ref_q;
      eof_pend_d = eof_pend_q;
      dly_d = dly_q;
      idle_d = idle_q;
      coll_d = 1'b0;
      rx_bit_d = rx_bit_q;
      rxv_d = 1'b0;
      edge_ev_d = 1'b0;
      if (samp_en_q)
      begin
         rx_prev_d = serial_receive_pin;
         if (dly_q != 3'h0)
         begin
            dly_d = dly_q - 3'h1;
            coll_d = (dly_q == 3'h1) && manch_q; // R22 R11
         end
         if (serial_receive_pin != rx_prev_q)
         begin
            edge_ev_d = 1'b1;
            run_d = 5'h01;
            idle_d = 1'b0;
            eof_pend_d = 1'b0;
            if (idle_q || !manch_q)
            begin
               mid_ref_d = 1'b0;
            end
            else if (run_q <= CMC_NARROW_MAX)
            begin
               dly_d = CMC_DLY_NARROW; // R12 R15 R16
            end
            else if (eof_pend_q && !serial_receive_pin)
            begin
               dly_d = CMC_DLY_EOF; // R20
            end
            else if (run_q <= CMC_HALF_MAX)
            begin
               mid_ref_d = ~mid_ref_q; // R14
               rx_bit_d = serial_receive_pin; // R10
               rxv_d = ~mid_ref_q;
            end
            else
            begin
               mid_ref_d = 1'b1;
               rx_bit_d = serial_receive_pin; // R10
               rxv_d = 1'b1;
            end
         end
         else
         begin
            run_d = run_inc;
            if (!manch_q)
            begin
               if (serial_receive_pin && run_inc == CMC_NRZ_IDLE)
               begin
                  idle_d = 1'b1;
               end
            end
            else if (!idle_q && !serial_receive_pin)
            begin
               if (run_inc == miss_thr)
               begin
                  dly_d = CMC_DLY_MISS; // R12 R17 R18
               end
            end
            else if (!idle_q)
            begin
               if (run_inc == miss_thr)
               begin
                  eof_pend_d = 1'b1; // R19
               end
               if (eof_pend_q && run_inc == miss_thr + CMC_IDLE_EXTRA)
               begin
                  idle_d = 1'b1; // R19 R21
                  eof_pend_d = 1'b0;
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_prev_q <= 1'b1;
         run_q <= 5'h00;
         mid_ref_q <= 1'b0;
         eof_pend_q <= 1'b0;
         dly_q <= 3'h0;
         idle_q <= 1'b1;
         coll_q <= 1'b0;
         rx_bit_q <= 1'b0;
         rxv_q <= 1'b0;
         edge_ev_q <= 1'b0;
      end
      else
      begin
         rx_prev_q <= rx_prev_d;
         run_q <= run_d;
         mid_ref_q <= mid_ref_d;
         eof_pend_q <= eof_pend_d;
         dly_q <= dly_d;
         idle_q <= idle_d;
         coll_q <= coll_d;
         rx_bit_q <= rx_bit_d;
         rxv_q <= rxv_d;
         edge_ev_q <= edge_ev_d;
      end
   end

   // Interframe space deference timer, counting whole bit times.
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         CMC_DEFER:
         begin
            if (idle_q)
            begin
               st_d = CMC_TIMING; // R6
               cnt_d = period;
            end
         end
         CMC_TIMING:
         begin
            if (edge_ev_q && half_q &&
               cmc_bkmode_t'(ctrl_q.bkmode) == CMC_BK_NORMAL)
            begin
               cnt_d = period; // R7 R8
            end
            else if (bit_en_q)
            begin
               if (cnt_q <= 9'h001)
               begin
                  st_d = CMC_OPEN; // R9
               end
               else
               begin
                  cnt_d = cnt_q - 9'h001;
               end
            end
         end
         CMC_OPEN:
         begin
            // Another station took the line before we started.
            if (edge_ev_q && !tx_pending)
            begin
               st_d = CMC_DEFER; // R6
            end
         end
         default:
         begin
            st_d = CMC_DEFER;
         end
      endcase
      half_d = (st_d == CMC_TIMING) && (cnt_d > {1'b0, period[8:1]}); // R4
      txok_d = (st_d == CMC_OPEN); // R9
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q <= CMC_TIMING; // R5
         cnt_q <= CMC_IFS_ZERO_PERIOD;
         half_q <= 1'b1;
         txok_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         half_q <= half_d;
         txok_q <= txok_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_allowed = txok_q;
   assign collision = coll_q;
   assign rx_bit = rx_bit_q;
   assign rx_bit_valid = rxv_q;
   assign line_idle_flag = idle_q;
   assign manchester_sel = manch_q;
endmodule // cmc_top
`default_nettype wire

// ===== common/cmc_pkg.sv
/*
 Constants, types and register map of the CSMA/CD line front end: the
 interframe space deference timer and the Manchester receive checker.
 Assumes a single 125 MHz clock and software access over APB.
*/
// Summary of operation
// R1 - Interframe spacing is programmable in even bit times from 2 to 256.
// R2 - Interframe period is spacing value times bit time; zero gives 256.
// R3 - Software writes load only the upper seven bits of the spacing register.
// R4 - Spacing low bit reads 1 in first half of period, 0 in second.
// R5 - Spacing resets to zero; bit time after reset is 8 clocks.
// R6 - Pending transmit defers while line active, then one full interframe.
// R7 - Normal backoff mode restarts the timer on activity in first half.
// R8 - Alternate or deterministic backoff mode never restarts the timer.
// R9 - An expired timer allows transmission even with activity on line.
// R10 - CSMA/CD mode selects Manchester; rising mid-bit is 1, falling is 0.
// R11 - External 1X clock option forces NRZ; no Manchester checking then.
// R12 - Collisions are missing rising, unexpected falling, or too short levels.
// R13 - Receive pin is sampled at eight times the bit rate.
// R14 - Jitter tolerated: one sample per half bit, two per full bit.
// R15 - Levels of three samples are valid; one or two samples collide.
// R16 - Narrow pulse collision flagged 3/8 to 1/2 bit after offending edge.
// R17 - Edge falling, no rise after six lows: collision at 1 to 1 1/8 bit.
// R18 - Mid falling, no rise: collision at 1 5/8 to 1 3/4 bit.
// R19 - High cell lacking mid fall is tentative end; one bit later sets idle.
// R20 - Falling edge during tentative end gives collision 1/2 to 5/8 bit later.
// R21 - End of frame is line high without transitions for two bit times.
// R22 - Each collision is reported as a single clock cycle pulse.
package cmc_pkg;
   localparam int CMC_AW = 12;
   localparam logic [CMC_AW-1:0] CMC_OFF_IFS = 12'h000;
   localparam logic [CMC_AW-1:0] CMC_OFF_CTRL = 12'h004;
   localparam logic [CMC_AW-1:0] CMC_OFF_STATUS = 12'h008;
   localparam logic [CMC_AW-1:0] CMC_OFF_SAMPDIV = 12'h00c;
   localparam int CMC_CTRL_W = 4;
   localparam int CMC_ST_IDLE = 0;
   localparam int CMC_ST_TXOK = 1;
   localparam int CMC_ST_COLL = 2;
   localparam int CMC_ST_RXBIT = 3;
   localparam int CMC_ST_HALF = 4;
   localparam logic [6:0] CMC_IFS_RST = 7'h00;
   localparam logic [CMC_CTRL_W-1:0] CMC_CTRL_RST = 4'h0;
   localparam logic [7:0] CMC_SAMPDIV_RST = 8'h00;
   localparam logic [8:0] CMC_IFS_ZERO_PERIOD = 9'h100;
   localparam logic [2:0] CMC_SAMP_LAST = 3'h7;
   localparam logic [4:0] CMC_NARROW_MAX = 5'h02;
   localparam logic [4:0] CMC_HALF_MAX = 5'h05;
   localparam logic [4:0] CMC_MISS_EDGE = 5'h06;
   localparam logic [4:0] CMC_MISS_MID = 5'h0b;
   localparam logic [4:0] CMC_IDLE_EXTRA = 5'h08;
   localparam logic [4:0] CMC_NRZ_IDLE = 5'h10;
   localparam logic [2:0] CMC_DLY_MISS = 3'h2;
   localparam logic [2:0] CMC_DLY_NARROW = 3'h3;
   localparam logic [2:0] CMC_DLY_EOF = 3'h4;
   typedef enum logic [1:0]
   {
      CMC_BK_NORMAL = 2'b00,
      CMC_BK_ALT = 2'b11
   } cmc_bkmode_t;
   typedef enum logic [1:0]
   {
      CMC_DEFER = 2'b00,
      CMC_TIMING = 2'b01,
      CMC_OPEN = 2'b11
   } cmc_ifs_state_t;
   typedef struct packed
   {
      logic [1:0] bkmode;
      logic ext_1x;
      logic csma;
   } cmc_ctrl_t;
endpackage

// ===== testbench/cmc_monitor.sv
/*
 Port checker of the CSMA/CD line front end, bound to cmc_top.
 Assumes SAMPDIV keeps its reset value, so a bit time is 8 clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module cmc_monitor
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset, active low
   input wire logic [cmc_pkg::CMC_AW-1:0] paddr, // Address
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic serial_receive_pin, // Line
   input wire logic tx_allowed, // Deference over
   input wire logic collision, // Collision pulse
   input wire logic rx_bit_valid, // Bit strobe
   input wire logic line_idle_flag, // Idle status
   input wire logic manchester_sel // Coding select
);
   import cmc_pkg::*;
   logic [7:0] hi_q;
   logic [7:0] hi_d;
   logic [6:0] ifs_q;
   logic [6:0] ifs_d;
   logic idl_q;
   logic txa_q;
   logic dfr_q;
   logic dfr_d;
   logic done;
   assign done = psel && penable && pready;
   // Counts clocks of unbroken high line and tracks the written spacing.
   // A drop of tx_allowed starts a deferral that the next idle ends.
   always_comb
   begin
      dfr_d = dfr_q;
      if (txa_q && !tx_allowed)
      begin
         dfr_d = 1'b1;
      end
      if (line_idle_flag && !idl_q)
      begin
         dfr_d = 1'b0;
      end
      hi_d = 8'h00;
      if (serial_receive_pin)
      begin
         hi_d = (hi_q == 8'hff) ? hi_q : hi_q + 8'h01;
      end
      ifs_d = ifs_q;
      if (done && pwrite && paddr == CMC_OFF_IFS)
      begin
         ifs_d = pwdata[7:1];
      end
   end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hi_q <= 8'h00;
         ifs_q <= 7'h00;
         idl_q <= 1'b1;
         txa_q <= 1'b0;
         dfr_q <= 1'b0;
      end
      else
      begin
         hi_q <= hi_d;
         ifs_q <= ifs_d;
         idl_q <= line_idle_flag;
         txa_q <= tx_allowed;
         dfr_q <= dfr_d;
      end
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_coll_one_cycle: assert property (collision |=> !collision)
      else $error("collision pulse longer than one cycle");
   a_rxv_one_cycle: assert property (rx_bit_valid |=> !rx_bit_valid)
      else $error("bit strobe longer than one cycle");
   a_quiet_no_coll: assert property (hi_q >= 8'h28 |-> !collision)
      else $error("collision on a quiet line");
   a_idle_high_run: assert property
      ($rose(line_idle_flag) |-> hi_q >= 8'h0c)
      else $error("idle flagged without a long high run");
   a_defer_min_period: assert property
      (dfr_q && line_idle_flag && !idl_q |=> !tx_allowed [*8])
      else $error("transmit allowed before interframe period");
   a_ifs_readback: assert property
      (done && !pwrite && paddr == CMC_OFF_IFS
       |-> prdata[31:1] == {24'h000000, ifs_q})
      else $error("spacing register read back wrong");
   a_mode_select: assert property
      (done && pwrite && paddr == CMC_OFF_CTRL |-> ##2
       manchester_sel == ($past(pwdata[0], 2) && !$past(pwdata[1], 2)))
      else $error("coding select does not follow control");
   a_nrz_quiet: assert property
      (!manchester_sel && !$past(manchester_sel, 4)
       |-> !collision && !rx_bit_valid)
      else $error("Manchester checking active in NRZ mode");
endmodule // cmc_monitor
bind cmc_top cmc_monitor mon_u (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .serial_receive_pin(serial_receive_pin), .tx_allowed(tx_allowed),
   .collision(collision), .rx_bit_valid(rx_bit_valid),
   .line_idle_flag(line_idle_flag), .manchester_sel(manchester_sel));
`default_nettype wire

// ===== testbench/cmc_line_model.sv
/*
 Other stations on the shared line, sending Manchester bits.
 Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cmc_line_model
(
   input wire logic pclk, // Clock
   output logic line // Line level, pulled high when released
);
   initial line = 1'b1;
   task automatic hold(input logic lvl, input int n);
      line <= lvl;
      repeat (n) @(posedge pclk);
   endtask
   // Sends n bits, first bit highest; j shifts each mid transition.
   task automatic send(input logic [15:0] bits, input int n, input int j);
      for (int i = n - 1; i >= 0; i--)
      begin
         hold(!bits[i], 4 + j);
         hold(bits[i], 4 - j);
      end
   endtask
endmodule // cmc_line_model
`default_nettype wire

// ===== testbench/testbench.sv
/*
 Self-checking bench of the CSMA/CD line front end over APB.
 Assumes SAMPDIV keeps its reset value, so a bit time is 8 clocks.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import cmc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic line, tx_pending, tx_allowed, collision, rx_bit, rx_bit_valid;
   logic line_idle_flag, manchester_sel;
   logic [CMC_AW-1:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [15:0] rx_sh;
   int miscompares, n_tests, n_coll, cyc;
   always #4 pclk = ~pclk;
   cmc_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_receive_pin(line), .tx_pending(tx_pending),
      .tx_allowed(tx_allowed), .collision(collision), .rx_bit(rx_bit),
      .rx_bit_valid(rx_bit_valid), .line_idle_flag(line_idle_flag),
      .manchester_sel(manchester_sel));
   cmc_line_model line_u (.pclk(pclk), .line(line));
   task automatic stop_test;
      $display("Compares %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (collision === 1'b1)
         n_coll++;
      if (rx_bit_valid === 1'b1)
         rx_sh <= {rx_sh[14:0], rx_bit};
      if (cyc == 12000)
      begin
         miscompares++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [CMC_AW-1:0] a,
      input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic frame(input logic [15:0] p, input int n, input int j);
      rx_sh <= 16'h0000;
      line_u.send(p, n, j);
      line_u.hold(1'b1, 40);
   endtask
   // Sends bits, holds a level, then counts clocks from the edge to b.
   task automatic viol(input logic [15:0] p, input int n, input logic a,
      input int na, input logic b, input int lo, input int hi);
      int t;
      line_u.send(p, n, 0);
      line_u.hold(a, na);
      line_u.hold(b, 0);
      t = 0;
      do
      begin
         @(posedge pclk);
         t++;
      end
      while (collision !== 1'b1 && t < 30);
      chk(t >= lo && t <= hi, 1'b1);
      line_u.hold(1'b1, 40);
   endtask
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      tx_pending = 1'b0;
      rx_sh = 16'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CMC_OFF_IFS, 32'h0);
      chk(d, 32'h0000_0001);
      repeat (1980) @(posedge pclk);
      chk(tx_allowed, 1'b0);
      repeat (70) @(posedge pclk);
      chk(tx_allowed, 1'b1);
      apb(1'b1, CMC_OFF_IFS, 32'h0000_00ff);
      apb(1'b0, CMC_OFF_IFS, 32'h0);
      chk(d, 32'h0000_00fe);
      apb(1'b0, 12'h010, 32'h0);
      chk({d[30:0], err}, 32'h1);
      apb(1'b0, CMC_OFF_SAMPDIV, 32'h0);
      chk(d, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, CMC_OFF_CTRL, 32'(i));
         @(posedge pclk);
         chk(manchester_sel, i == 1);
      end
      apb(1'b1, CMC_OFF_CTRL, 32'h1);
      frame(16'h00b2, 8, 0);
      chk(rx_sh[7:0], 8'hb2);
      frame(16'h00b2, 8, 1);
      chk(rx_sh[7:0], 8'hb2);
      chk(n_coll, 0);
      chk(line_idle_flag, 1'b1);
      viol(16'h1, 1, 1'b0, 2, 1'b1, 3, 7);
      viol(16'h1, 1, 1'b0, 1, 1'b0, 7, 12);
      viol(16'h2, 2, 1'b0, 1, 1'b0, 8, 13);
      viol(16'h1, 1, 1'b1, 8, 1'b0, 4, 9);
      apb(1'b0, CMC_OFF_STATUS, 32'h0);
      chk({d[CMC_ST_COLL], d[CMC_ST_IDLE]}, 2'b11);
      apb(1'b1, CMC_OFF_STATUS, 32'h0000_0004);
      apb(1'b0, CMC_OFF_STATUS, 32'h0);
      chk(d[CMC_ST_COLL], 1'b0);
      apb(1'b1, CMC_OFF_CTRL, 32'h3);
      viol(16'h1, 1, 1'b0, 2, 1'b1, 30, 30);
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, CMC_OFF_CTRL, (m == 1) ? 32'hd : 32'h1);
         apb(1'b1, CMC_OFF_IFS, 32'h20);
         line_u.hold(1'b0, 4);
         tx_pending <= 1'b1;
         line_u.hold(1'b1, 4);
         while (line_idle_flag !== 1'b1) @(posedge pclk);
         line_u.hold(1'b1, 40);
         apb(1'b0, CMC_OFF_IFS, 32'h0);
         chk(d[0], 1'b1);
         line_u.hold(1'b0, 4);
         line_u.hold(1'b1, 220);
         chk(tx_allowed, m);
         if (m == 0)
         begin
            apb(1'b0, CMC_OFF_IFS, 32'h0);
            chk(d[0], 1'b0);
            repeat (100) @(posedge pclk);
            chk(tx_allowed, 1'b1);
         end
         tx_pending <= 1'b0;
      end
      stop_test();
   end
endmodule // testbench
`default_nettype wire
